// *** shared/arq_regs.vh ***
// Register offsets, field positions, reset values and timing constants of the retransmission controller.
`ifndef ARQ_REGS_VH
`define ARQ_REGS_VH

`define ARQ_ADDR_W 4
`define ARQ_OFS_CTRL 4'h0
`define ARQ_OFS_MAXRETRY 4'h1
`define ARQ_OFS_MAXACKT 4'h2
`define ARQ_OFS_STATUS 4'h3
`define ARQ_OFS_IRQ_STAT 4'h4
`define ARQ_OFS_IRQ_MASK 4'h5
`define ARQ_OFS_RETRY_CNT 4'h6

`define ARQ_CTRL_SS_ONLY 0
`define ARQ_CTRL_RX_TMO_EN 1
`define ARQ_CTRL_RST 2'h0

`define ARQ_MAXRETRY_RST 8'h03
`define ARQ_MAXACKT_RST 24'h009C40

`define ARQ_IRQ_TXFAIL 0
`define ARQ_IRQ_TXDONE 1
`define ARQ_IRQ_RXDROP 2
`define ARQ_IRQ_RXTMO 3
`define ARQ_IRQ_W 4

`define ARQ_ACKT_US 1
`define ARQ_CLK_MHZ 40
`define ARQ_ACKT_TICK (`ARQ_ACKT_US * `ARQ_CLK_MHZ)

`define ARQ_PRI3 2'h3
`define ARQ_ACK_UTC_TYPE 2'h1

`endif

// *** hdl/arq_retx_ctrl.v ***
// Acknowledgement and retransmission controller for unicast link-layer frames.
//
// The strobed register port and the address map are this design's own decisions.
`include "arq_regs.vh"

module arq_retx_ctrl (
    // Clock and reset.
    input wire i_ref_clk,
    input wire i_rst,
    // Register port.
    input wire [3:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [31:0] o_reg_rdata,
    output wire o_irq,
    // Frame request from the upper layer.
    input wire i_frm_valid,
    input wire i_frm_unicast,
    input wire i_frm_ack_need,
    input wire [7:0] i_frm_num_mpdu,
    output wire o_frm_ready,
    output reg o_frm_release,
    // MPDU transmit path to the physical layer.
    input wire i_tx_opportunity,
    input wire i_pri3_ready,
    output wire o_tx_start,
    output wire o_tx_pri3,
    output reg [7:0] o_tx_mpdu_idx,
    output reg o_tx_ack_req,
    output reg o_tx_ss_mode,
    input wire i_tx_done,
    input wire i_pri3_done,
    // Received acknowledgement for the transmitted MPDU.
    input wire i_ack_valid,
    input wire i_ack_ok,
    input wire i_ack_utc,
    // Received frame check results.
    input wire i_rx_valid,
    input wire i_rx_ack_req,
    input wire i_rx_hdr_ok,
    input wire i_rx_addr_ok,
    input wire i_rx_seq_ok,
    input wire i_rx_type_ok,
    input wire i_rx_ms,
    input wire [7:0] i_rx_lpcs_ok,
    input wire [7:0] i_rx_lpdu_cnt,
    input wire i_rx_mpcs_ok,
    input wire [1:0] i_rx_pri,
    input wire i_rx_first,
    input wire i_rx_last,
    // Acknowledgement answer, receive status and transmit failure.
    output reg o_ack_send,
    output reg o_ack_nack,
    output reg [1:0] o_ack_type,
    output reg [7:0] o_ack_ext,
    output reg o_rx_drop,
    output reg o_rx_pri3_int,
    output reg o_rx_discard,
    output reg o_tx_fail,
    // Hold status toward the scheduler.
    output wire o_dest_hold
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SEND = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_HOLD = 4'b1000;

    reg [3:0] state_q;
    reg [1:0] ctrl_q;
    reg [7:0] max_retry_q;
    reg [23:0] max_ackt_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_mask_q;
    reg [7:0] num_q;
    reg [7:0] retry_q;
    reg ack_need_q;
    reg ss_force_q;
    reg pri3_act_q;
    reg [5:0] tick_q;
    reg [23:0] ackt_q;
    reg rx_busy_q;
    reg [5:0] rx_tick_q;
    reg [23:0] rx_t_q;
    reg pri3_go;
    reg [3:0] ev;

    wire tick_hit = (tick_q == `ARQ_ACKT_TICK - 1);
    wire rx_tick_hit = (rx_tick_q == `ARQ_ACKT_TICK - 1);
    wire ackt_exp = (ackt_q >= max_ackt_q) && (state_q != ST_IDLE);
    wire rx_chk_ok = i_rx_hdr_ok && i_rx_addr_ok && i_rx_seq_ok && i_rx_type_ok;
    wire [7:0] lp_mask = (i_rx_lpdu_cnt >= 8'h08) ? 8'hFF : ((8'h01 << i_rx_lpdu_cnt[2:0]) - 8'h01);

    assign o_frm_ready = (state_q == ST_IDLE);
    assign o_dest_hold = (state_q == ST_HOLD);
    assign o_tx_start = (i_tx_opportunity && state_q == ST_SEND && !pri3_act_q && !i_pri3_ready) || pri3_go;
    assign o_tx_pri3 = pri3_go;
    assign o_irq = |(irq_stat_q & irq_mask_q);

    always @*
    begin
        pri3_go = i_pri3_ready && i_tx_opportunity && !pri3_act_q;
    end

    // Transmit side: one LLC frame in flight, MPDUs sent and acknowledged in order.
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= ST_IDLE;
            num_q <= 8'h00;
            retry_q <= 8'h00;
            ack_need_q <= 1'b0;
            ss_force_q <= 1'b0;
            pri3_act_q <= 1'b0;
            tick_q <= 6'h00;
            ackt_q <= 24'h000000;
            o_tx_mpdu_idx <= 8'h00;
            o_tx_ack_req <= 1'b0;
            o_tx_ss_mode <= 1'b0;
            o_tx_fail <= 1'b0;
            o_frm_release <= 1'b0;
        end
        else
        begin
            o_tx_fail <= 1'b0;
            o_frm_release <= 1'b0;
            if (pri3_go)
                pri3_act_q <= 1'b1;
            else if (i_pri3_done)
                pri3_act_q <= 1'b0;
            if (state_q == ST_IDLE || pri3_act_q)
            begin
                tick_q <= tick_q;
            end
            else if (tick_hit)
            begin
                tick_q <= 6'h00;
                ackt_q <= ackt_q + 24'h000001;
            end
            else
            begin
                tick_q <= tick_q + 6'h01;
            end
            case (state_q)
                ST_IDLE:
                begin
                    if (i_frm_valid)
                    begin
                        num_q <= i_frm_num_mpdu;
                        ack_need_q <= i_frm_ack_need && i_frm_unicast;
                        o_tx_ack_req <= i_frm_ack_need && i_frm_unicast;
                        o_tx_mpdu_idx <= 8'h00;
                        retry_q <= 8'h00;
                        ss_force_q <= 1'b0;
                        o_tx_ss_mode <= 1'b0;
                        tick_q <= 6'h00;
                        ackt_q <= 24'h000000;
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    if (ackt_exp)
                    begin
                        o_tx_fail <= 1'b1;
                        o_frm_release <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    else if (o_tx_start && !pri3_go)
                    begin
                        o_tx_ss_mode <= ss_force_q;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT, ST_HOLD:
                begin
                    if (ackt_exp)
                    begin
                        o_tx_fail <= 1'b1;
                        o_frm_release <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    else if (!ack_need_q && i_tx_done)
                    begin
                        if (o_tx_mpdu_idx + 8'h01 >= num_q)
                        begin
                            o_frm_release <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            o_tx_mpdu_idx <= o_tx_mpdu_idx + 8'h01;
                            state_q <= ST_SEND;
                        end
                    end
                    else if (ack_need_q && i_ack_valid)
                    begin
                        if (i_ack_ok && !i_ack_utc)
                        begin
                            retry_q <= 8'h00;
                            if (o_tx_mpdu_idx + 8'h01 >= num_q)
                            begin
                                o_frm_release <= 1'b1;
                                state_q <= ST_IDLE;
                            end
                            else
                            begin
                                o_tx_mpdu_idx <= o_tx_mpdu_idx + 8'h01;
                                state_q <= ST_SEND;
                            end
                        end
                        else if (retry_q + 8'h01 >= max_retry_q)
                        begin
                            o_tx_fail <= 1'b1;
                            o_frm_release <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            retry_q <= retry_q + 8'h01;
                            // The format is raised here so that it already stands with the resend's start.
                            if (i_ack_utc)
                            begin
                                ss_force_q <= 1'b1;
                                o_tx_ss_mode <= 1'b1;
                            end
                            state_q <= ST_HOLD;
                        end
                    end
                    else if (state_q == ST_HOLD)
                    begin
                        state_q <= ST_SEND;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Receive side: validity checks, error decision and acknowledgement answer.
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_ack_send <= 1'b0;
            o_ack_nack <= 1'b0;
            o_ack_type <= 2'h0;
            o_ack_ext <= 8'h00;
            o_rx_drop <= 1'b0;
            o_rx_pri3_int <= 1'b0;
            o_rx_discard <= 1'b0;
            rx_busy_q <= 1'b0;
            rx_tick_q <= 6'h00;
            rx_t_q <= 24'h000000;
        end
        else
        begin
            o_ack_send <= 1'b0;
            o_rx_drop <= 1'b0;
            o_rx_pri3_int <= 1'b0;
            o_rx_discard <= 1'b0;
            if (i_rx_valid)
            begin
                o_rx_pri3_int <= !i_rx_seq_ok && (i_rx_pri == `ARQ_PRI3);
                if (i_rx_ack_req && !rx_chk_ok)
                begin
                    o_rx_drop <= 1'b1;
                end
                else if (i_rx_ack_req)
                begin
                    o_ack_send <= 1'b1;
                    o_ack_ext <= {6'h00, 1'b0, !i_rx_ms};
                    if (i_rx_ms && ctrl_q[`ARQ_CTRL_SS_ONLY])
                    begin
                        o_ack_type <= `ARQ_ACK_UTC_TYPE;
                        o_ack_nack <= 1'b1;
                    end
                    else if (i_rx_ms)
                    begin
                        o_ack_type <= 2'h0;
                        o_ack_nack <= ((i_rx_lpcs_ok | ~lp_mask) != 8'hFF);
                    end
                    else
                    begin
                        o_ack_type <= 2'h0;
                        o_ack_nack <= !i_rx_mpcs_ok;
                    end
                end
            end
            if (i_rx_valid && rx_chk_ok && i_rx_first && !rx_busy_q)
            begin
                rx_busy_q <= !i_rx_last;
                rx_tick_q <= 6'h00;
                rx_t_q <= 24'h000000;
            end
            else if (rx_busy_q)
            begin
                if (i_rx_valid && rx_chk_ok && i_rx_last)
                    rx_busy_q <= 1'b0;
                else if (ctrl_q[`ARQ_CTRL_RX_TMO_EN] && rx_t_q >= max_ackt_q)
                begin
                    rx_busy_q <= 1'b0;
                    o_rx_discard <= 1'b1;
                end
                rx_tick_q <= rx_tick_hit ? 6'h00 : rx_tick_q + 6'h01;
                if (rx_tick_hit)
                    rx_t_q <= rx_t_q + 24'h000001;
            end
        end
    end

    // Register file and sticky interrupt status; a new event wins over a clear.
    always @*
    begin
        ev = 4'h0;
        ev[`ARQ_IRQ_TXFAIL] = o_tx_fail;
        ev[`ARQ_IRQ_TXDONE] = o_frm_release && !o_tx_fail;
        ev[`ARQ_IRQ_RXDROP] = o_rx_drop;
        ev[`ARQ_IRQ_RXTMO] = o_rx_discard;
    end

    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_q <= `ARQ_CTRL_RST;
            max_retry_q <= `ARQ_MAXRETRY_RST;
            max_ackt_q <= `ARQ_MAXACKT_RST;
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
            o_reg_rdata <= 32'h00000000;
        end
        else
        begin
            if (i_reg_wr && i_reg_addr == `ARQ_OFS_IRQ_STAT)
                irq_stat_q <= (irq_stat_q & ~i_reg_wdata[3:0]) | ev;
            else
                irq_stat_q <= irq_stat_q | ev;
            if (i_reg_wr)
            begin
                if (i_reg_addr == `ARQ_OFS_CTRL)
                    ctrl_q <= i_reg_wdata[1:0];
                else if (i_reg_addr == `ARQ_OFS_MAXRETRY)
                    max_retry_q <= i_reg_wdata[7:0];
                else if (i_reg_addr == `ARQ_OFS_MAXACKT)
                    max_ackt_q <= i_reg_wdata[23:0];
                else if (i_reg_addr == `ARQ_OFS_IRQ_MASK)
                    irq_mask_q <= i_reg_wdata[3:0];
            end
            o_reg_rdata <= 32'h00000000;
            if (i_reg_rd)
            begin
                if (i_reg_addr == `ARQ_OFS_CTRL)
                    o_reg_rdata <= {30'h00000000, ctrl_q};
                else if (i_reg_addr == `ARQ_OFS_MAXRETRY)
                    o_reg_rdata <= {24'h000000, max_retry_q};
                else if (i_reg_addr == `ARQ_OFS_MAXACKT)
                    o_reg_rdata <= {8'h00, max_ackt_q};
                else if (i_reg_addr == `ARQ_OFS_STATUS)
                    o_reg_rdata <= {20'h00000, rx_busy_q, pri3_act_q, ss_force_q, 1'b0, o_tx_mpdu_idx};
                else if (i_reg_addr == `ARQ_OFS_IRQ_STAT)
                    o_reg_rdata <= {28'h0000000, irq_stat_q};
                else if (i_reg_addr == `ARQ_OFS_IRQ_MASK)
                    o_reg_rdata <= {28'h0000000, irq_mask_q};
                else if (i_reg_addr == `ARQ_OFS_RETRY_CNT)
                    o_reg_rdata <= {24'h000000, retry_q};
            end
        end
    end

endmodule // arq_retx_ctrl

// *** bench/arq_retx_ctrl_assertions.sv ***
// Concurrent checks on the ports of the retransmission controller.
module arq_retx_ctrl_assertions (
    // Clock, reset and register writes.
    input logic i_ref_clk,
    input logic i_rst,
    input logic [3:0] i_reg_addr,
    input logic [31:0] i_reg_wdata,
    input logic i_reg_wr,
    // Frame and transmit path.
    input logic i_frm_valid, i_frm_unicast, i_frm_ack_need, o_frm_ready, o_frm_release,
    input logic i_tx_opportunity, i_pri3_ready, i_pri3_done, o_tx_start, o_tx_pri3, o_tx_ack_req,
    input logic i_ack_valid, i_ack_ok, o_dest_hold, o_tx_fail,
    // Receive path.
    input logic i_rx_valid, i_rx_ack_req, i_rx_hdr_ok, i_rx_addr_ok, i_rx_seq_ok, i_rx_type_ok,
    input logic i_rx_ms, i_rx_mpcs_ok, o_ack_send, o_ack_nack, o_rx_drop, o_rx_pri3_int,
    input logic [7:0] i_rx_lpcs_ok, i_rx_lpdu_cnt, o_ack_ext,
    input logic [1:0] i_rx_pri, o_ack_type
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ss_only_q, want_ack_q, busy_q, p3_q;
    wire take = i_frm_valid && o_frm_ready;
    wire chk_ok = i_rx_hdr_ok && i_rx_addr_ok && i_rx_seq_ok && i_rx_type_ok;
    wire [8:0] lp_m = (9'h001 << i_rx_lpdu_cnt) - 9'h001;
    wire lp_bad = |(~i_rx_lpcs_ok & lp_m[7:0]);

    // Shadow state, so the checks need no view of the bodies.
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ss_only_q <= 1'b0;
            want_ack_q <= 1'b0;
            busy_q <= 1'b0;
            p3_q <= 1'b0;
        end
        else
        begin
            if (i_reg_wr && i_reg_addr == 4'h0)
                ss_only_q <= i_reg_wdata[0];
            if (take)
                want_ack_q <= i_frm_unicast && i_frm_ack_need;
            busy_q <= take || (busy_q && !o_frm_release);
            p3_q <= (o_tx_start && o_tx_pri3) || (p3_q && !i_pri3_done);
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_rx_good;
        i_rx_valid && i_rx_ack_req && chk_ok;
    endsequence
    sequence s_ack_out;
        o_ack_send && !o_rx_drop;
    endsequence

    ack_req_tx_a: assert property (
        o_tx_start && !o_tx_pri3 |-> o_tx_ack_req == want_ack_q) else $error("ack request wrong");
    rx_drop_a: assert property (
        i_rx_valid && i_rx_ack_req && !chk_ok |=> o_rx_drop && !o_ack_send) else $error("bad frame acked");
    ms_err_a: assert property (
        s_rx_good ##0 (i_rx_ms && !ss_only_q) |=> s_ack_out ##0 o_ack_nack == $past(lp_bad))
        else $error("segment verdict wrong");
    ss_err_a: assert property (
        s_rx_good ##0 !i_rx_ms |=> s_ack_out ##0 o_ack_nack == !$past(i_rx_mpcs_ok))
        else $error("single verdict wrong");
    utc_ack_a: assert property (
        s_rx_good ##0 (i_rx_ms && ss_only_q) |=> s_ack_out ##0 (o_ack_type == 2'h1 && o_ack_ext[7:2] == 6'h00))
        else $error("refusal answer wrong");
    ext_form_a: assert property (
        s_rx_good ##0 !i_rx_ms |=> o_ack_ext == 8'h01) else $error("extension wrong");
    pri3_int_a: assert property (
        i_rx_valid && !i_rx_seq_ok && i_rx_pri == 2'h3 |=> o_rx_pri3_int) else $error("interrupt frame missed");
    pri3_pre_a: assert property (
        i_pri3_ready && i_tx_opportunity && !p3_q |-> o_tx_start && o_tx_pri3) else $error("preemption late");
    hold_set_a: assert property (
        i_ack_valid && !i_ack_ok |=> o_dest_hold || o_tx_fail) else $error("no hold after error");
    hold_tx_a: assert property (
        o_dest_hold |-> !o_tx_start || o_tx_pri3) else $error("sent while held");
    fail_rel_a: assert property (
        o_tx_fail |-> ##[0:1] o_frm_release) else $error("failed frame kept");
    one_frame_a: assert property (
        busy_q && !o_frm_release |-> !o_frm_ready) else $error("frame overlap");
endmodule // arq_retx_ctrl_assertions

bind arq_retx_ctrl arq_retx_ctrl_assertions u_arq_chk (.*);

// *** bench/arq_peer_model.sv ***
// Peer link layer that answers each sent MPDU that requests an acknowledgement after a latency, unless muted.
module arq_peer_model (
    input logic i_ref_clk,
    input logic i_rst,
    input logic i_start,
    input logic i_ack_req,
    input logic [3:0] i_lat,
    input logic i_mute,
    input logic i_good,
    input logic i_utc,
    output logic o_ack_valid,
    output logic o_ack_ok,
    output logic o_ack_utc,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] cnt_q;
    logic req_q;

    always @(posedge i_ref_clk or posedge i_rst)
    begin
        o_ack_valid <= 1'b0;
        o_done <= 1'b0;
        if (i_rst)
        begin
            cnt_q <= 5'h00;
            req_q <= 1'b0;
            o_ack_ok <= 1'b0;
            o_ack_utc <= 1'b0;
        end
        else if (i_start)
        begin
            cnt_q <= {1'b0, i_lat} + 5'h01;
            req_q <= i_ack_req;
        end
        else if (cnt_q == 5'h01)
        begin
            cnt_q <= 5'h00;
            o_done <= 1'b1;
            o_ack_valid <= req_q && !i_mute;
            o_ack_ok <= i_good;
            o_ack_utc <= i_utc;
        end
        else
        begin
            // Qualifiers toggle outside the answer so a stale value never passes.
            cnt_q <= cnt_q - {4'h0, cnt_q != 5'h00};
            o_ack_ok <= !o_ack_ok;
            o_ack_utc <= !o_ack_utc;
        end
    end
endmodule // arq_peer_model

// *** bench/test_arq_retx_ctrl.sv ***
// Self-checking testbench of the retransmission controller.
`include "arq_regs.vh"
module test_arq_retx_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, o_irq;
    logic i_frm_valid = 1'b0, i_frm_unicast = 1'b0, i_frm_ack_need = 1'b0, o_frm_ready, o_frm_release;
    logic i_tx_opportunity = 1'b1, i_pri3_ready = 1'b0, i_pri3_done = 1'b0, o_tx_start, o_tx_pri3;
    logic o_tx_ack_req, o_tx_ss_mode, i_tx_done, i_ack_valid, i_ack_ok, i_ack_utc, o_dest_hold;
    logic i_rx_valid = 1'b0, i_rx_ack_req = 1'b0, i_rx_hdr_ok = 1'b0, i_rx_addr_ok = 1'b0, i_rx_seq_ok = 1'b0;
    logic i_rx_type_ok = 1'b0, i_rx_ms = 1'b0, i_rx_mpcs_ok = 1'b0, i_rx_first = 1'b0, i_rx_last = 1'b0;
    logic o_ack_send, o_ack_nack, o_rx_drop, o_rx_pri3_int, o_rx_discard, o_tx_fail;
    logic [3:0] i_reg_addr = 4'h0, nbad = 4'h0, bad_n = 4'h0, p_lat = 4'h0;
    logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata;
    logic [7:0] i_frm_num_mpdu = 8'h01, o_tx_mpdu_idx, o_ack_ext, i_rx_lpcs_ok = 8'h00, i_rx_lpdu_cnt = 8'h01;
    logic [1:0] i_rx_pri = 2'h0, o_ack_type;
    logic p_mute = 1'b0, p_utc = 1'b0, last_ss, last_req;
    logic [7:0] last_idx;
    int error_cnt = 0, check_count = 0, n_start = 0, n_p3 = 0, n_fail = 0, n_rel = 0, n_hold = 0, t;
    int seed = 32'h0EEBB30A;

    arq_retx_ctrl DUT (.*);
    arq_peer_model u_peer (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_start(o_tx_start && !o_tx_pri3),
        .i_ack_req(o_tx_ack_req), .i_lat(p_lat), .i_mute(p_mute), .i_good(nbad == 4'h0),
        .i_utc(p_utc && nbad != 4'h0), .o_ack_valid(i_ack_valid), .o_ack_ok(i_ack_ok),
        .o_ack_utc(i_ack_utc), .o_done(i_tx_done));

    initial
    begin
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk)
    begin
        // Counters other than n_p3 restart with each accepted frame, so this process alone writes them.
        if (i_frm_valid && o_frm_ready)
        begin
            n_start = 0;
            n_fail = 0;
            n_hold = 0;
            n_rel = 0;
            nbad <= bad_n;
        end
        if (o_tx_start && !o_tx_pri3)
        begin
            n_start++;
            last_idx = o_tx_mpdu_idx;
            last_ss = o_tx_ss_mode;
            last_req = o_tx_ack_req;
        end
        n_p3 += o_tx_start && o_tx_pri3;
        n_fail += o_tx_fail;
        n_rel += o_frm_release;
        n_hold += o_dest_hold;
        if (i_ack_valid && nbad != 4'h0)
            nbad <= nbad - 4'h1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick;
        @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        tick();
        i_reg_wr <= 1'b0;
        tick();
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string what);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        tick();
        i_reg_rd <= 1'b0;
        check(what, o_reg_rdata, exp);
        tick();
    endtask

    task automatic frame(input logic uni, input logic [7:0] n);
        t = 0;
        p_lat = 4'($random(seed));
        i_frm_unicast <= uni;
        i_frm_ack_need <= 1'b1;
        i_frm_num_mpdu <= n;
        i_frm_valid <= 1'b1;
        tick();
        i_frm_valid <= 1'b0;
        while (n_rel == 0 && t < 2000)
        begin
            tick();
            t++;
        end
        check("release", n_rel, 32'h1);
    endtask

    function automatic logic lp_err(input logic [7:0] ok, input logic [7:0] cnt);
        logic [8:0] m;
        m = (9'h001 << cnt) - 9'h001;
        return |(~ok & m[7:0]);
    endfunction

    task automatic rx_one(input logic ss, input logic fst);
        logic bad;
        i_rx_ack_req <= fst || $random(seed) % 4 != 0;
        i_rx_hdr_ok <= fst || $random(seed) % 8 != 0;
        i_rx_addr_ok <= fst || $random(seed) % 8 != 0;
        i_rx_seq_ok <= fst || $random(seed) % 6 != 0;
        i_rx_type_ok <= fst || $random(seed) % 8 != 0;
        i_rx_ms <= 1'($random(seed));
        i_rx_lpcs_ok <= ($random(seed) % 3 == 0) ? 8'($random(seed)) : 8'hFF;
        i_rx_lpdu_cnt <= 8'(($random(seed) & 7) + 1);
        i_rx_mpcs_ok <= $random(seed) % 3 != 0;
        i_rx_pri <= 2'($random(seed));
        i_rx_first <= fst;
        i_rx_last <= !fst;
        i_rx_valid <= 1'b1;
        tick();
        i_rx_valid <= 1'b0;
        bad = !(i_rx_hdr_ok && i_rx_addr_ok && i_rx_seq_ok && i_rx_type_ok);
        check("drop", o_rx_drop, i_rx_ack_req && bad);
        check("ack", o_ack_send, i_rx_ack_req && !bad);
        check("p3int", o_rx_pri3_int, !i_rx_seq_ok && i_rx_pri == 2'h3);
        if (i_rx_ack_req && !bad && ss && i_rx_ms)
            check("utc", o_ack_type, `ARQ_ACK_UTC_TYPE);
        else if (i_rx_ack_req && !bad)
            check("nack", o_ack_nack, i_rx_ms ? lp_err(i_rx_lpcs_ok, i_rx_lpdu_cnt) : !i_rx_mpcs_ok);
        tick();
    endtask

    task automatic summarize;
        $display("Checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        tick();
        rchk(`ARQ_OFS_MAXRETRY, `ARQ_MAXRETRY_RST, "maxretry");
        rchk(`ARQ_OFS_MAXACKT, `ARQ_MAXACKT_RST, "maxackt");
        rchk(4'hF, 32'h0, "unmapped");
        wr(4'hF, 32'hFFFFFFFF);
        wr(`ARQ_OFS_MAXACKT, 32'h5);
        wr(`ARQ_OFS_MAXRETRY, 32'h2);
        rchk(`ARQ_OFS_MAXRETRY, 32'h2, "maxretry");
        frame(1'b1, 8'h03);
        check("starts", n_start, 32'h3);
        check("lastidx", last_idx, 8'h02);
        rchk(`ARQ_OFS_IRQ_STAT, 32'h2, "txdone");
        wr(`ARQ_OFS_IRQ_STAT, 32'h2);
        frame(1'b0, 8'h02);
        check("bcast", last_req, 1'b0);
        check("bstarts", n_start, 32'h2);
        bad_n = 4'h1;
        p_utc = 1'b1;
        frame(1'b1, 8'h01);
        check("resend", n_start, 32'h2);
        check("hold", n_hold, 32'h1);
        check("residx", last_idx, 8'h00);
        check("ssmode", last_ss, 1'b1);
        bad_n = 4'hF;
        frame(1'b1, 8'h01);
        check("tries", n_start, 32'h2);
        check("fail", n_fail, 32'h1);
        bad_n = 4'h0;
        check("masked", o_irq, 1'b0);
        wr(`ARQ_OFS_IRQ_MASK, 32'h1);
        check("irq", o_irq, 1'b1);
        wr(`ARQ_OFS_IRQ_STAT, 32'hF);
        check("irqclr", o_irq, 1'b0);
        p_mute = 1'b1;
        frame(1'b1, 8'h01);
        check("tmo", t >= 150 && t <= 260, 1'b1);
        check("tmofail", n_fail, 32'h1);
        fork
            frame(1'b1, 8'h01);
            begin
                i_pri3_ready <= 1'b1;
                tick();
                i_pri3_ready <= 1'b0;
                repeat (300) tick();
                i_pri3_done <= 1'b1;
                tick();
                i_pri3_done <= 1'b0;
            end
        join
        check("freeze", t >= 440, 1'b1);
        check("p3", n_p3, 32'h1);
        p_mute = 1'b0;
        for (int i = 0; i < 80; i++)
        begin
            if (i == 40)
                wr(`ARQ_OFS_CTRL, 32'h1);
            rx_one(i >= 40, 1'b0);
        end
        wr(`ARQ_OFS_CTRL, 32'h2);
        rx_one(1'b0, 1'b1);
        t = 0;
        while (!o_rx_discard && t < 400)
        begin
            tick();
            t++;
        end
        check("rxtmo", t >= 150 && t <= 260, 1'b1);
        summarize();
    end

    // The run needs well under ten thousand cycles.
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        error_cnt++;
        summarize();
    end
endmodule // test_arq_retx_ctrl
